// file: igd_host.v
/*
 host controller of an isolated gate driver: drives the complementary
 control pair, pulses fault clear, runs the converter shutdown pin and
 watches fault and power-ready.
 assumes the driver pins are asynchronous and an external pull-up on
 the fault line; the testbench takes the frequency pin output and enable as two separate wires.
*/
`timescale 1ns/1ns
`default_nettype none
`include "igd_defines.vh"
module igd_host #(
    parameter STARTUP_CYC = `IGD_STARTUP_US * `IGD_CLK_MHZ,
    parameter CLEAR_CYC = (`IGD_CLEAR_PULSE_NS * `IGD_CLK_MHZ + 999) / 1000,
    parameter RETRY_CYC = `IGD_RETRY_S * `IGD_US_PER_S * `IGD_CLK_MHZ,
    parameter USE_NEG = 0
) (
    input wire clk,
    input wire rst,
    input wire gate_cmd,
    input wire conv_off_req,
    input wire auto_clear,
    input wire clear_req,
    input wire fault_out_n,
    input wire power_ready,
    output reg ctrl_pos,
    output reg ctrl_neg,
    output reg fault_clear_n,
    output reg converter_off_freq_pin_o,
    output reg converter_off_freq_pin_oe,
    output reg fault_seen,
    output reg ready_seen,
    output reg startup_done,
    output reg restart_wait
);
    wire [1:0] pin_s;
    wire flt_n_s;
    wire rdy_s;
    reg [`IGD_ST_W-1:0] st_r;
    reg [`IGD_ST_W-1:0] st_nxt;
    reg [39:0] cnt_r;
    reg [39:0] cnt_nxt;
    reg drive_on;

    // ==========================================
    // pin synchronisers
    igd_sync #(.W(2)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({fault_out_n, power_ready}),
        .q(pin_s)
    );
    assign flt_n_s = pin_s[1];
    assign rdy_s = pin_s[0];

    // ==========================================
    // sequencer
    always @* begin
        st_nxt = st_r;
        cnt_nxt = cnt_r + 40'h1;
        case (st_r)
            `IGD_ST_START: begin
                // frequency pin left floating so straps are sampled
                if (cnt_r >= STARTUP_CYC - 1) begin
                    st_nxt = `IGD_ST_WAIT;
                    cnt_nxt = 40'h0;
                end
            end
            `IGD_ST_WAIT: begin
                if (rdy_s) begin
                    st_nxt = `IGD_ST_RUN;
                    cnt_nxt = 40'h0;
                end else if (cnt_r >= RETRY_CYC - 1) begin
                    st_nxt = `IGD_ST_START;
                    cnt_nxt = 40'h0;
                end
            end
            `IGD_ST_RUN: begin
                cnt_nxt = 40'h0;
                if (!rdy_s) begin
                    st_nxt = `IGD_ST_WAIT;
                end else if (!flt_n_s) begin
                    st_nxt = `IGD_ST_HOLD;
                end
            end
            `IGD_ST_HOLD: begin
                cnt_nxt = 40'h0;
                // lockout faults release by themselves, so no clear
                if (!rdy_s) begin
                    st_nxt = `IGD_ST_WAIT;
                end else if (flt_n_s) begin
                    st_nxt = `IGD_ST_RUN;
                end else if (auto_clear || clear_req) begin
                    st_nxt = `IGD_ST_CLEAR;
                end
            end
            `IGD_ST_CLEAR: begin
                if (cnt_r >= CLEAR_CYC - 1) begin
                    st_nxt = `IGD_ST_RUN;
                    cnt_nxt = 40'h0;
                end
            end
            default: begin
                st_nxt = `IGD_ST_START;
                cnt_nxt = 40'h0;
            end
        endcase
    end

    // gate command only while running and no fault showing
    always @* begin
        drive_on = gate_cmd && (st_r == `IGD_ST_RUN) && flt_n_s;
    end

    // ==========================================
    // registers and pin drive
    always @(posedge clk) begin
        if (rst) begin
            st_r <= `IGD_ST_START;
            cnt_r <= 40'h0;
            ctrl_pos <= `IGD_POS_OFF;
            ctrl_neg <= `IGD_NEG_OFF;
            fault_clear_n <= 1'h1;
            converter_off_freq_pin_o <= 1'h0;
            converter_off_freq_pin_oe <= 1'h0;
            fault_seen <= 1'h0;
            ready_seen <= 1'h0;
            startup_done <= 1'h0;
            restart_wait <= 1'h0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            if (USE_NEG != 0) begin
                // positive held high, negative is the low-true command
                ctrl_pos <= `IGD_POS_ON;
                ctrl_neg <= drive_on ? `IGD_NEG_ON : `IGD_NEG_OFF;
            end else begin
                // negative held low, positive is the command
                ctrl_neg <= `IGD_NEG_ON;
                ctrl_pos <= drive_on ? `IGD_POS_ON : `IGD_POS_OFF;
            end
            if (st_nxt == `IGD_ST_CLEAR || st_nxt == `IGD_ST_HOLD) begin
                // positive low is a hard off in either mode
                ctrl_pos <= `IGD_POS_OFF;
            end
            fault_clear_n <= (st_nxt != `IGD_ST_CLEAR);
            if (st_nxt == `IGD_ST_START) begin
                converter_off_freq_pin_oe <= 1'h0;
                converter_off_freq_pin_o <= 1'h0;
            end else begin
                converter_off_freq_pin_oe <= 1'h1;
                converter_off_freq_pin_o <= conv_off_req;
            end
            fault_seen <= !flt_n_s && rdy_s;
            ready_seen <= rdy_s;
            startup_done <= (st_nxt != `IGD_ST_START);
            restart_wait <= (st_nxt == `IGD_ST_WAIT) && !rdy_s;
        end
    end
endmodule
`default_nettype wire

// file: igd_defines.vh
/*
 definitions shared by the host controller of an isolated gate driver:
 pin levels, input encodings, state codes and timing constants.
 assumes a 100 MHz clock and inclusion by bare name.
*/
// Operation
// - with negative input low, positive input high turns gate on.
// - with positive input high, negative input low turns gate on.
// - desaturation pulls fault low until controller drives clear low.
// - external shutdown stops converter switching while asserted.
// - controller keeps frequency pin hi-z at startup, low running, high off.
`ifndef IGD_DEFINES_VH
`define IGD_DEFINES_VH

// ==========================================
// timing
`define IGD_CLK_MHZ 100
`define IGD_STARTUP_US 1000
`define IGD_CLEAR_PULSE_NS 1000
`define IGD_RETRY_S 40
// wide on purpose: the retry count overflows a 32-bit integer
`define IGD_US_PER_S 40'h00000F4240
// ==========================================
// drive encodings on the complementary pair
`define IGD_POS_OFF 1'h0
`define IGD_NEG_ON 1'h0
`define IGD_NEG_OFF 1'h1
`define IGD_POS_ON 1'h1
// ==========================================
// host states, one-hot
`define IGD_ST_W 5
`define IGD_ST_START 5'h01
`define IGD_ST_WAIT 5'h02
`define IGD_ST_RUN 5'h04
`define IGD_ST_CLEAR 5'h08
`define IGD_ST_HOLD 5'h10

`endif

// file: igd_sync.v
/*
 two flip-flop synchroniser, one per bit.
 assumes inputs come from pins outside the clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module igd_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;
    // ==========================================
    // synchroniser stages
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk) begin
                if (rst) begin
                    meta_r[i] <= 1'h0;
                    sync_r[i] <= 1'h0;
                end else begin
                    meta_r[i] <= d[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate
    assign q = sync_r;
endmodule
`default_nettype wire

// file: igd_dev_model.sv
/* device model: complementary input, fault latch, lockout.
 assumes host pins and bench fault commands on one clock. */
`timescale 1ns/1ns
`default_nettype none
module igd_dev_model (
    input wire logic clk,
    input wire logic ctrl_pos,
    input wire logic ctrl_neg,
    input wire logic fault_clear_n,
    input wire logic desat,
    input wire logic uvlo,
    output logic fault_out_n,
    output logic power_ready,
    output logic gate_on
);
    // ========================================
    // gate and fault latch
    logic latch_r = 1'h0;
    assign gate_on = ctrl_pos & ~ctrl_neg & ~latch_r & ~uvlo;
    always @(posedge clk) begin
        if (!fault_clear_n)
            latch_r <= 1'h0;
        else if (desat && gate_on)
            latch_r <= 1'h1;
    end
    // resolved open-drain level, pull-up assumed
    assign fault_out_n = ~(latch_r | uvlo);
    assign power_ready = ~uvlo;
endmodule
`default_nettype wire

// file: igd_host_chk.sv
/* timing checker for the gate driver host.
 assumes the negative input is unused (active-high mode). */
`timescale 1ns/1ns
`default_nettype none
module igd_host_chk #(parameter CLEAR_CYC = 100) (
    input wire logic clk,
    input wire logic rst,
    input wire logic conv_off_req,
    input wire logic auto_clear,
    input wire logic clear_req,
    input wire logic ctrl_pos,
    input wire logic ctrl_neg,
    input wire logic fault_clear_n,
    input wire logic converter_off_freq_pin_o,
    input wire logic converter_off_freq_pin_oe,
    input wire logic startup_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ========================================
    // clear pulse length, counted not unrolled
    int low_cnt_r = 0;
    always @(posedge clk) low_cnt_r <= fault_clear_n ? 0 : low_cnt_r + 1;
    sequence s_off_held; (startup_done && conv_off_req) [*3]; endsequence
    sequence s_on_held; (startup_done && !conv_off_req) [*3]; endsequence
    a_neg_held_low: assert property (ctrl_pos |-> !ctrl_neg)
        else $error("negative input high while gate on");
    a_clear_len: assert property ($rose(fault_clear_n) |-> low_cnt_r == CLEAR_CYC)
        else $error("clear pulse length wrong");
    a_clear_cause: assert property ($fell(fault_clear_n) |-> $past(clear_req) || $past(auto_clear))
        else $error("clear pulse without request");
    a_pin_float: assert property (!startup_done |-> !converter_off_freq_pin_oe)
        else $error("frequency pin driven at startup");
    a_off_high: assert property (s_off_held |-> converter_off_freq_pin_oe && converter_off_freq_pin_o)
        else $error("shutdown not driven high");
    a_run_low: assert property (s_on_held |-> converter_off_freq_pin_oe && !converter_off_freq_pin_o)
        else $error("frequency pin not held low");
endmodule
bind igd_host igd_host_chk #(.CLEAR_CYC(CLEAR_CYC)) i_igd_host_chk (.*);
`default_nettype wire

// file: igd_host_tb_top.sv
/* self-checking bench for the gate driver host.
 assumes the device model and a fault-free clock. */
`timescale 1ns/1ns
`default_nettype none
module igd_host_tb_top;
    logic clk = 1'h0, rst = 1'h1, gate_cmd = 1'h0, conv_off_req = 1'h0;
    logic auto_clear = 1'h0, clear_req = 1'h0, desat = 1'h0, uvlo = 1'h0;
    wire fault_out_n, power_ready, gate_on, ctrl_pos, ctrl_neg, fault_clear_n;
    wire converter_off_freq_pin_o, converter_off_freq_pin_oe, fault_seen;
    wire ready_seen, startup_done, restart_wait;
    wire [8:0] obs = {startup_done, restart_wait, ready_seen, fault_seen,
        ctrl_neg, converter_off_freq_pin_oe, converter_off_freq_pin_o,
        fault_clear_n, ctrl_pos};
    string nm[9] = '{"ctrl_pos", "fault_clear_n", "pin_o", "pin_oe",
        "ctrl_neg", "fault_seen", "ready_seen", "restart_wait",
        "startup_done"};
    int error_cnt = 0, check_count = 0, seed = 32'hbe6cfcb1;
    logic [31:0] r;
    logic [4:0] e;
    logic [4:0] exp_q[$];
    always #5 clk = ~clk;
    // short counts keep the run small
    igd_host #(.STARTUP_CYC(20), .CLEAR_CYC(3), .RETRY_CYC(50)) i_igd_host (.*);
    igd_dev_model i_igd_dev_model (.*);
    // ========================================
    // queue of notes, compared by the monitor
    task automatic note(input logic [3:0] s, input logic v);
        exp_q.push_back({s, v});
    endtask
    task automatic check(input logic seen, input logic exp, input int idx);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %0b seen %0b", nm[idx], exp, seen);
        end
    endtask
    // several notes may be taken in one cycle, so drain them all
    always @(posedge clk) begin
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(obs[e[4:1]], e[0], e[4:1]);
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_for(input int s, input logic v);
        int n;
        n = 0;
        while (obs[s] !== v && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (obs[s] !== v) begin
            error_cnt++;
            report_and_stop();
        end
    endtask
    // ========================================
    // main sequence
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'h0;
        note(3, 1'h0);
        note(8, 1'h0);
        gate_cmd = 1'h1;
        wait_for(0, 1'h1);
        note(2, 1'h0);
        note(4, 1'h0);
        note(6, 1'h1);
        note(8, 1'h1);
        repeat (40) begin
            r = $random(seed);
            gate_cmd = r[0];
            @(negedge clk);
            note(0, gate_cmd);
        end
        for (int m = 0; m < 2; m++) begin
            gate_cmd = 1'h1;
            wait_for(0, 1'h1);
            desat = 1'h1;
            wait_for(0, 1'h0);
            desat = 1'h0;
            repeat (4) begin
                gate_cmd = ~gate_cmd;
                @(negedge clk);
                note(0, 1'h0);
                note(1, 1'h1);
                note(5, 1'h1);
            end
            clear_req = (m == 0);
            auto_clear = (m == 1);
            wait_for(1, 1'h0);
            gate_cmd = 1'h1;
            wait_for(0, 1'h1);
            clear_req = 1'h0;
            auto_clear = 1'h0;
        end
        // lockout: fault self-releases, no clear pulse expected
        uvlo = 1'h1;
        wait_for(0, 1'h0);
        repeat (10) begin
            @(negedge clk);
            note(1, 1'h1);
            note(5, 1'h0);
            note(6, 1'h0);
            note(7, 1'h1);
        end
        uvlo = 1'h0;
        wait_for(0, 1'h1);
        conv_off_req = 1'h1;
        wait_for(2, 1'h1);
        note(3, 1'h1);
        conv_off_req = 1'h0;
        wait_for(2, 1'h0);
        note(3, 1'h1);
        @(negedge clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
